// ==== spcb_defs.svh ====
`ifndef SPCB_DEFS_SVH
`define SPCB_DEFS_SVH

// register byte offsets
`define SPCB_OFF_CTRL2 12'h000
`define SPCB_OFF_STAT1 12'h004
`define SPCB_OFF_CTRL1 12'h008
`define SPCB_OFF_TXSTAT 12'h00C
`define SPCB_OFF_EVT 12'h010
`define SPCB_OFF_MASK 12'h014

// control two fields
`define SPCB_C2_TIE 7
`define SPCB_C2_DONE_IRQ_EN 6
`define SPCB_C2_RIE 5
`define SPCB_C2_IDLE_IRQ_EN 4
`define SPCB_C2_SEN 3
`define SPCB_C2_LON 2
`define SPCB_C2_RWU 1
`define SPCB_C2_SBK 0

// control one fields
`define SPCB_C1_LOOP 0
`define SPCB_C1_RX_SOURCE_SELECT 1
`define SPCB_C1_DIR 2
`define SPCB_C1_WAKE 3
`define SPCB_C1_LBRK 4

// status one fields
`define SPCB_S1_TX_EMPTY_FLAG 7
`define SPCB_S1_TC 6
`define SPCB_S1_RX_FULL_FLAG 5
`define SPCB_S1_IDLE 4

// event bits
`define SPCB_EV_IDLEQ 0
`define SPCB_EV_BRKQ 1
`define SPCB_EV_WAKE 2
`define SPCB_EV_PINREL 3

// reset values
`define SPCB_RST_CTRL2 8'h00
`define SPCB_RST_CTRL1 8'h00
`define SPCB_RST_MASK 4'h0

// break lengths in bit times
`define SPCB_BRK_SHORT 4'hA
`define SPCB_BRK_LONG 4'hD

`endif

// ==== spcb_pkg.sv ====
package spcb_pkg;
	typedef enum logic [3:0] {
		SPCB_IDLE = 4'h1,
		SPCB_BREAK = 4'h2,
		SPCB_PREAMB = 4'h4,
		SPCB_DRAIN = 4'h8
	} spcb_tx_state_t;
endpackage

// ==== spcb_queue.sv ====
`timescale 1ns/1ps
`include "spcb_defs.svh"

// queues idle and break characters toward the transmit shifter
module spcb_queue
	import spcb_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// control
	input wire logic sender_enable_i,
	input wire logic send_break_i,
	input wire logic long_break_select_i,
	input wire logic idle_req_i,
	input wire logic bit_tick_i,
	input wire logic data_busy_i,
	// state
	output logic queue_busy_o,
	output logic break_active_o,
	output logic preamble_active_o,
	output logic brk_start_o
);
	spcb_tx_state_t state_q;
	spcb_tx_state_t state_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic idle_pend_q;
	logic brk_pend_q;
	logic sbk_prev_q;
	logic [3:0] brk_len;
	logic idle_pend_d;
	logic brk_pend_d;

	// break of 10 or 13 low bit times, picked by long_break_select_i
	assign brk_len = long_break_select_i ? `SPCB_BRK_LONG : `SPCB_BRK_SHORT;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		idle_pend_d = idle_pend_q | idle_req_i;
		// a rising edge queues one break; holding high keeps queuing
		brk_pend_d = brk_pend_q | (send_break_i & ~sbk_prev_q);
		brk_start_o = 1'b0;
		case (state_q)
			SPCB_IDLE: begin
				// queued characters wait for current data to finish
				// start on a bit boundary so a character is whole bit times
				if (!data_busy_i && bit_tick_i) begin
					if (brk_pend_q || send_break_i) begin
						state_d = SPCB_BREAK;
						cnt_d = brk_len;
						brk_pend_d = 1'b0;
						brk_start_o = 1'b1;
					end else if (idle_pend_q) begin
						state_d = SPCB_PREAMB;
						cnt_d = `SPCB_BRK_SHORT;
						idle_pend_d = idle_req_i;
					end
				end
			end
			SPCB_BREAK, SPCB_PREAMB: begin
				if (bit_tick_i) begin
					cnt_d = cnt_q - 4'h1;
					if (cnt_q == 4'h1) begin
						if (state_q == SPCB_BREAK && send_break_i) begin
							// held send break chains the next break with no gap
							cnt_d = brk_len;
							brk_pend_d = 1'b0;
							brk_start_o = 1'b1;
						end else begin
							state_d = SPCB_IDLE;
						end
					end
				end
			end
			default: begin
				state_d = SPCB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			state_q <= SPCB_IDLE;
			cnt_q <= 4'h0;
			idle_pend_q <= 1'b0;
			brk_pend_q <= 1'b0;
			sbk_prev_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			idle_pend_q <= idle_pend_d;
			brk_pend_q <= brk_pend_d;
			sbk_prev_q <= send_break_i;
		end
	end

	assign break_active_o = (state_q == SPCB_BREAK);
	assign preamble_active_o = (state_q == SPCB_PREAMB);
	assign queue_busy_o = (state_q != SPCB_IDLE) | idle_pend_q | brk_pend_q;
	wire unused_en = sender_enable_i;
endmodule

// ==== spcb_top.sv ====
`timescale 1ns/1ps
`include "spcb_defs.svh"

module spcb_top
	import spcb_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// datapath flags and events
	input wire logic tx_empty_flag_i,
	input wire logic tx_data_busy_i,
	input wire logic rx_full_flag_i,
	input wire logic idle_flag_i,
	input wire logic [3:0] status_low_i,
	input wire logic rx_idle_line_i,
	input wire logic rx_msb_set_i,
	input wire logic bit_tick_i,
	// control toward datapath
	output logic sender_on_o,
	output logic listener_active_o,
	output logic rx_standby_o,
	output logic break_active_o,
	output logic preamble_active_o,
	// pins
	input wire logic txd_pin_i,
	output logic txd_o,
	output logic txd_oe_o,
	input wire logic txd_shift_i,
	output logic rx_data_o,
	output logic txd_owned_o,
	output logic rxd_owned_o,
	input wire logic rxd_pin_i,
	// interrupts
	output logic irq_o,
	output logic evt_irq_o
);
	// ****************************************
	// registers
	// ****************************************
	logic [7:0] ctrl2_q;
	logic [7:0] ctrl1_q;
	logic [3:0] evt_q;
	logic [3:0] mask_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic done_q;
	logic done_seen_q;
	logic irq_q;
	logic evt_irq_q;
	logic txd_q;
	logic txd_oe_q;
	logic rxd_q;
	logic owned_q;
	logic rx_own_q;
	logic [1:0] rxd_sync_q;
	logic [1:0] txd_sync_q;
	logic idle_req_q;

	// ****************************************
	// bus decode
	// ****************************************
	wire setup = psel_i & ~penable_i;
	// writes land at the access edge, where the master samples ready
	wire acc_ph = psel_i & penable_i & pready_q;
	wire wr = acc_ph & pwrite_i;
	wire rd = setup & ~pwrite_i;
	wire hit_c2 = paddr_i == `SPCB_OFF_CTRL2;
	wire hit_s1 = paddr_i == `SPCB_OFF_STAT1;
	wire hit_c1 = paddr_i == `SPCB_OFF_CTRL1;
	wire hit_tx = paddr_i == `SPCB_OFF_TXSTAT;
	wire hit_ev = paddr_i == `SPCB_OFF_EVT;
	wire hit_mk = paddr_i == `SPCB_OFF_MASK;
	wire mapped = hit_c2 | hit_s1 | hit_c1 | hit_tx | hit_ev | hit_mk;
	wire wr_c2 = wr & hit_c2;
	wire [7:0] wdat = pwdata_i[7:0];

	// ****************************************
	// transmitter control
	// ****************************************
	wire sen = ctrl2_q[`SPCB_C2_SEN];
	wire send_break_ctl = ctrl2_q[`SPCB_C2_SBK];
	wire loop_sel = ctrl1_q[`SPCB_C1_LOOP];
	wire src_sel = ctrl1_q[`SPCB_C1_RX_SOURCE_SELECT];
	wire single_wire = loop_sel & src_sel;
	wire q_busy;
	wire brk_act;
	wire pre_act;
	wire brk_start;
	wire tx_busy = tx_data_busy_i | q_busy;
	// 0-then-1 in one write cannot be seen; a rewrite of 1 after 0 is the cue
	wire sen_rise = wr_c2 & wdat[`SPCB_C2_SEN] & ~sen;
	wire idle_req = sen_rise & tx_busy;

	spcb_queue u_queue (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.sender_enable_i(sen),
		.send_break_i(send_break_ctl),
		.long_break_select_i(ctrl1_q[`SPCB_C1_LBRK]),
		.idle_req_i(idle_req_q),
		.bit_tick_i(bit_tick_i),
		.data_busy_i(tx_data_busy_i),
		.queue_busy_o(q_busy),
		.break_active_o(brk_act),
		.preamble_active_o(pre_act),
		.brk_start_o(brk_start)
	);

	// pin stays owned while anything is still going out
	wire own_d = sen | tx_busy;
	// single-wire receive direction turns the driver off
	wire drive_d = own_d & ~(single_wire & ~ctrl1_q[`SPCB_C1_DIR]);
	wire txd_d = brk_act ? 1'b0 : (pre_act ? 1'b1 : txd_shift_i);
	wire rx_own_d = ctrl2_q[`SPCB_C2_LON] & ~loop_sel;
	wire rx_in = single_wire ? txd_sync_q[1] : (loop_sel ? txd_d : rxd_sync_q[1]);

	// ****************************************
	// wakeup and flags
	// ****************************************
	wire wake_hit = ctrl2_q[`SPCB_C2_RWU] &
		(ctrl1_q[`SPCB_C1_WAKE] ? rx_msb_set_i : rx_idle_line_i);
	// done flag clears on preamble or break queue after a status read
	wire done_clr = done_seen_q & (idle_req | (wr_c2 & wdat[`SPCB_C2_SBK]));
	wire done_now = tx_empty_flag_i & ~tx_busy;
	wire [7:0] stat1 = {tx_empty_flag_i, done_q, rx_full_flag_i, idle_flag_i, status_low_i};
	wire [3:0] evt_set = {~own_d & owned_q, wake_hit, brk_start, idle_req};
	wire [7:0] ctrl2_wr = wdat & ~({7'h00, wake_hit} << `SPCB_C2_RWU);
	wire irq_d = (ctrl2_q[`SPCB_C2_TIE] & tx_empty_flag_i) |
		(ctrl2_q[`SPCB_C2_DONE_IRQ_EN] & done_q) |
		(ctrl2_q[`SPCB_C2_RIE] & rx_full_flag_i) |
		(ctrl2_q[`SPCB_C2_IDLE_IRQ_EN] & idle_flag_i);

	// ****************************************
	// read mux
	// ****************************************
	wire [7:0] rd_byte = hit_c2 ? ctrl2_q :
		hit_s1 ? stat1 :
		hit_c1 ? ctrl1_q :
		hit_tx ? {4'h0, owned_q, q_busy, brk_act, pre_act} :
		hit_ev ? {4'h0, evt_q} :
		hit_mk ? {4'h0, mask_q} : 8'h00;

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			ctrl2_q <= `SPCB_RST_CTRL2;
		end else if (wr_c2) begin
			ctrl2_q <= ctrl2_wr;
		end else if (wake_hit) begin
			ctrl2_q[`SPCB_C2_RWU] <= 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			ctrl1_q <= `SPCB_RST_CTRL1;
			mask_q <= `SPCB_RST_MASK;
		end else begin
			if (wr & hit_c1) begin
				ctrl1_q <= {3'h0, wdat[4:0]};
			end
			if (wr & hit_mk) begin
				mask_q <= wdat[3:0];
			end
		end
	end

	// set wins over a write-one clear
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			evt_q <= 4'h0;
		end else begin
			evt_q <= (evt_q & ~((wr & hit_ev) ? wdat[3:0] : 4'h0)) | evt_set;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			done_q <= 1'b1;
			done_seen_q <= 1'b0;
			idle_req_q <= 1'b0;
		end else begin
			idle_req_q <= idle_req;
			if (done_clr) begin
				done_q <= 1'b0;
				done_seen_q <= 1'b0;
			end else begin
				done_q <= done_now | (done_q & ~tx_busy);
				if (rd & hit_s1 & done_q) begin
					done_seen_q <= 1'b1;
				end
			end
		end
	end

	// status register has no write path at all
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~mapped;
			prdata_q <= rd ? {24'h000000, rd_byte} : 32'h0000_0000;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			rxd_sync_q <= 2'b11;
			txd_sync_q <= 2'b11;
			txd_q <= 1'b1;
			txd_oe_q <= 1'b0;
			owned_q <= 1'b0;
			rx_own_q <= 1'b0;
			rxd_q <= 1'b1;
			irq_q <= 1'b0;
			evt_irq_q <= 1'b0;
		end else begin
			rxd_sync_q <= {rxd_sync_q[0], rxd_pin_i};
			txd_sync_q <= {txd_sync_q[0], txd_pin_i};
			txd_q <= txd_d;
			txd_oe_q <= drive_d;
			owned_q <= own_d;
			rx_own_q <= rx_own_d;
			rxd_q <= rx_in;
			irq_q <= irq_d;
			evt_irq_q <= |(evt_q & mask_q);
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign txd_o = txd_q;
	assign txd_oe_o = txd_oe_q;
	assign txd_owned_o = owned_q;
	assign rxd_owned_o = rx_own_q;
	assign rx_data_o = rxd_q;
	assign irq_o = irq_q;
	assign evt_irq_o = evt_irq_q;
	assign sender_on_o = owned_q;
	assign listener_active_o = rx_own_q;
	assign rx_standby_o = ctrl2_q[`SPCB_C2_RWU];
	assign break_active_o = brk_act;
	assign preamble_active_o = pre_act;
endmodule

// ==== spcb_assertions.sv ====
`timescale 1ns/1ps
// ****
// port checker
// ****
module spcb_assertions (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// line control
	input wire logic sender_on_o,
	input wire logic txd_owned_o,
	input wire logic listener_active_o,
	input wire logic rxd_owned_o,
	input wire logic break_active_o,
	input wire logic preamble_active_o,
	input wire logic txd_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("ready held");
	ready_setup_a: assert property (psel_i && !penable_i |=> pready_o)
		else $error("ready missing");
	err_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("read data outside access");
	tx_own_a: assert property (sender_on_o == txd_owned_o)
		else $error("sender ownership split");
	rx_own_a: assert property (listener_active_o == rxd_owned_o)
		else $error("listener ownership split");
	queue_excl_a: assert property (!(break_active_o && preamble_active_o))
		else $error("break and idle together");
	break_low_a: assert property ($rose(break_active_o) |-> ##[0:1] !txd_o)
		else $error("break not low");
	break_drive_a: assert property ($past(break_active_o) |-> !txd_o)
		else $error("line high in break");
	idle_high_a: assert property ($past(preamble_active_o) |-> txd_o)
		else $error("line low in idle character");
	queue_own_a: assert property (break_active_o || preamble_active_o |=> txd_owned_o)
		else $error("pin released with queue busy");
endmodule
bind spcb_top spcb_assertions u_chk (.clock_i, .resetn_i, .psel_i, .penable_i, .prdata_o,
	.pready_o, .pslverr_o, .sender_on_o, .txd_owned_o, .listener_active_o, .rxd_owned_o,
	.break_active_o, .preamble_active_o, .txd_o);

// ==== spcb_partner.sv ====
`timescale 1ns/1ps
// ****
// remote node: bit timing, idle receive line, break length meter
// ****
module spcb_partner (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// line
	input wire logic line_i,
	output logic bit_tick_o,
	output logic rxd_o,
	output logic [3:0] brk_len_o
);
	logic [1:0] div_q;
	logic [3:0] low_q;
	assign bit_tick_o = (div_q == 2'h3);
	// marking level, nothing sent toward the port
	assign rxd_o = 1'b1;
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			div_q <= 2'h0;
			low_q <= 4'h0;
			brk_len_o <= 4'h0;
		end else begin
			div_q <= div_q + 2'h1;
			if (bit_tick_o && !line_i) begin
				low_q <= low_q + 4'h1;
			end
			// latch on the first high after a low stretch
			if (line_i && low_q != 4'h0) begin
				brk_len_o <= low_q;
				low_q <= 4'h0;
			end
		end
	end
endmodule

// ==== spcb_tb.sv ====
`timescale 1ns/1ps
`include "spcb_defs.svh"
module testbench;
	logic clock_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic tx_empty_flag_i, tx_data_busy_i, rx_full_flag_i, idle_flag_i;
	logic rx_idle_line_i, rx_msb_set_i, tick, rxd, txd_o, txd_oe_o, rx_data_o, shift;
	logic sender_on_o, listener_active_o, rx_standby_o, break_active_o, preamble_active_o;
	logic txd_owned_o, rxd_owned_o, irq_o, evt_irq_o;
	logic [3:0] brk_len, stat_lo;
	// released line is pulled up
	wire txd_line = txd_oe_o ? txd_o : 1'b1;
	int failures = 0, checks = 0;
	spcb_top u_dut (.clock_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .tx_empty_flag_i, .tx_data_busy_i, .rx_full_flag_i,
		.idle_flag_i, .status_low_i(stat_lo), .rx_idle_line_i, .rx_msb_set_i, .bit_tick_i(tick),
		.sender_on_o, .listener_active_o, .rx_standby_o, .break_active_o, .preamble_active_o,
		.txd_pin_i(txd_line), .txd_o, .txd_oe_o, .txd_shift_i(shift), .rx_data_o, .txd_owned_o,
		.rxd_owned_o, .rxd_pin_i(rxd), .irq_o, .evt_irq_o);
	spcb_partner u_far (.clock_i, .resetn_i, .line_i(txd_line), .bit_tick_o(tick),
		.rxd_o(rxd), .brk_len_o(brk_len));
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	task automatic print_verdict;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// holds the request until ready is sampled, bounded wait
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clock_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (pready_o !== 1'b1) begin
			failures++;
			$display("[ERR] pready expected 1 seen %b", pready_o);
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		cyc(2);
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return break_active_o;
			1: return preamble_active_o;
			default: return txd_owned_o;
		endcase
	endfunction
	task automatic wait_on(input int k, input logic v);
		int n;
		for (n = 0; n < 400 && sig(k) !== v; n++) @(posedge clock_i);
		chk("wait", v, sig(k));
	endtask
	task automatic t_regs;
		apb(0, `SPCB_OFF_CTRL2, 0);
		chk("ctrl2 reset", {24'h0, `SPCB_RST_CTRL2}, rd);
		apb(1, `SPCB_OFF_CTRL2, 32'hF0);
		apb(0, `SPCB_OFF_CTRL2, 0);
		chk("ctrl2 rw", 32'hF0, rd);
		apb(1, `SPCB_OFF_CTRL2, 0);
		apb(0, `SPCB_OFF_STAT1, 0);
		chk("done at reset", 1, rd[`SPCB_S1_TC]);
		apb(1, `SPCB_OFF_STAT1, 32'hFFFF_FF0A);
		chk("stat write err", 0, err);
		apb(0, `SPCB_OFF_STAT1, 0);
		chk("stat ro", 32'hF5, rd);
		apb(0, 12'h018, 0);
		chk("unmapped", 1, err);
		chk("unmapped rd", 0, rd);
	endtask
	task automatic t_irq;
		for (int i = 4; i < 8; i++) begin
			apb(1, `SPCB_OFF_CTRL2, 32'h1 << i);
			cyc(3);
			chk("irq on", 1, irq_o);
		end
		apb(1, `SPCB_OFF_CTRL2, 0);
		cyc(3);
		chk("irq off", 0, irq_o);
		rx_full_flag_i <= 1'b0;
		apb(1, `SPCB_OFF_CTRL2, 32'h20);
		cyc(3);
		chk("irq flag low", 0, irq_o);
		apb(1, `SPCB_OFF_CTRL2, 0);
	endtask
	task automatic t_tx;
		chk("oe before", 0, txd_oe_o);
		apb(1, `SPCB_OFF_CTRL2, 32'h8);
		chk("sender oe", 1, txd_oe_o);
		tx_data_busy_i <= 1'b1;
		apb(1, `SPCB_OFF_CTRL2, 0);
		chk("owned busy", 1, txd_owned_o);
		apb(0, `SPCB_OFF_EVT, 0);
		chk("no idle yet", 0, rd[`SPCB_EV_IDLEQ]);
		apb(1, `SPCB_OFF_CTRL2, 32'h8);
		apb(0, `SPCB_OFF_EVT, 0);
		chk("idle queued", 1, rd[`SPCB_EV_IDLEQ]);
		apb(1, `SPCB_OFF_MASK, 32'h1);
		chk("evt irq", 1, evt_irq_o);
		tx_data_busy_i <= 1'b0;
		wait_on(1, 1'b1);
		shift <= 1'b0;
		cyc(2);
		chk("idle char high", 1, txd_o);
		shift <= 1'b1;
		wait_on(1, 1'b0);
		apb(1, `SPCB_OFF_EVT, 32'h1);
		chk("evt cleared", 0, evt_irq_o);
		apb(1, `SPCB_OFF_CTRL2, 0);
		wait_on(2, 1'b0);
		chk("oe off", 0, txd_oe_o);
		apb(0, `SPCB_OFF_EVT, 0);
		chk("pin released", 1, rd[`SPCB_EV_PINREL]);
	endtask
	task automatic t_brk(input logic lng, input logic [3:0] lo);
		apb(1, `SPCB_OFF_CTRL1, {27'h0, lng, 4'h0});
		apb(1, `SPCB_OFF_CTRL2, 32'h9);
		wait_on(0, 1'b1);
		cyc(2);
		chk("break low", 0, txd_o);
		apb(1, `SPCB_OFF_CTRL2, 32'h8);
		apb(0, `SPCB_OFF_STAT1, 0);
		chk("done in break", 0, rd[`SPCB_S1_TC]);
		wait_on(0, 1'b0);
		cyc(3);
		chk("break len", 1, brk_len === lo || brk_len === lo + 4'h1);
	endtask
	task automatic t_rx;
		apb(1, `SPCB_OFF_CTRL2, 32'h4);
		chk("rx owned", 1, rxd_owned_o);
		apb(1, `SPCB_OFF_CTRL1, 32'h1);
		chk("loop frees rx", 0, rxd_owned_o);
		shift <= 1'b0;
		cyc(2);
		chk("loop data", 0, rx_data_o);
		shift <= 1'b1;
		apb(1, `SPCB_OFF_CTRL2, 32'hC);
		apb(1, `SPCB_OFF_CTRL1, 32'h3);
		chk("single rx", 0, txd_oe_o);
		apb(1, `SPCB_OFF_CTRL1, 32'h7);
		chk("single tx", 1, txd_oe_o);
		apb(1, `SPCB_OFF_CTRL1, 0);
	endtask
	task automatic pulse(input logic m);
		if (m) rx_msb_set_i <= 1'b1;
		else rx_idle_line_i <= 1'b1;
		@(posedge clock_i);
		rx_msb_set_i <= 1'b0;
		rx_idle_line_i <= 1'b0;
		cyc(4);
	endtask
	task automatic t_wake;
		apb(1, `SPCB_OFF_CTRL1, 32'h8);
		apb(1, `SPCB_OFF_CTRL2, 32'h6);
		pulse(1'b0);
		chk("mark waits", 1, rx_standby_o);
		pulse(1'b1);
		chk("mark wakes", 0, rx_standby_o);
		apb(1, `SPCB_OFF_CTRL1, 0);
		apb(1, `SPCB_OFF_CTRL2, 32'h6);
		pulse(1'b0);
		chk("idle wakes", 0, rx_standby_o);
	endtask
	initial begin
		#2000000;
		failures++;
		print_verdict();
	end
	initial begin
		{resetn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		{tx_data_busy_i, rx_idle_line_i, rx_msb_set_i} = '0;
		shift = 1'b1;
		stat_lo = 4'h5;
		{tx_empty_flag_i, rx_full_flag_i, idle_flag_i} = 3'h7;
		cyc(4);
		resetn_i <= 1'b1;
		t_regs();
		t_irq();
		t_tx();
		t_brk(1'b0, `SPCB_BRK_SHORT);
		t_brk(1'b1, `SPCB_BRK_LONG);
		t_rx();
		t_wake();
		print_verdict();
	end
endmodule
